// ===== common/pcr_pkg.sv
/*
  constants for the second phy control register block: offsets, bit
  positions, reset value and settle counts. assumes a 32-bit avalon
  slave with byte addresses and a 16-bit register in the low half.
*/
// Summary of operation
// R1 - control register at management address 0x000A
// R2 - bit15: transmitter off on 100M link drop
// R3 - bit14 fibre select, reset from strap
// R4 - bit6 selects fast parallel-detect link-up
// R5 - mdix speed-up modes force bit6 set
// R6 - bit5 forces full duplex vs forced partner
// R7 - bit4: led only on 100M copper full-duplex
// R8 - enhanced led mode suppresses activity blink
// R9 - bit3 isolates mii on half-duplex/10M links; the code isolates half-duplex 100M links on copper only, not on fibre
// R10 - bit2 resets one, enables idle symbol errors
// R11 - bit1 zero enables odd-nibble detection
// R12 - odd nibble end extends tx enable, error
// R13 - bit0 one: rmii data on receive clock
// R14 - bit0 zero: rmii data on crystal reference
// R15 - reserved bits 13..7 written back unchanged
`default_nettype none
package pcr_pkg;
  localparam int unsigned      ADDR_W         = 8;
  localparam int unsigned      REG_W          = 16;
  localparam logic [7:0]       IDX_CTRL_TWO   = 8'h0A;
  localparam logic [7:0]       IDX_STATUS     = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = {IDX_CTRL_TWO[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = {IDX_STATUS[5:0], 2'b00};
  localparam logic [REG_W-1:0] RESET_CTRL_TWO = 16'h0104;
  localparam int unsigned      BIT_FAR_DROP   = 15;
  localparam int unsigned      BIT_FIBRE      = 14;
  localparam int unsigned      BIT_FAST_PD    = 6;
  localparam int unsigned      BIT_EXT_FDX    = 5;
  localparam int unsigned      BIT_ENH_LED    = 4;
  localparam int unsigned      BIT_ISO_MII    = 3;
  localparam int unsigned      BIT_IDLE_ERR   = 2;
  localparam int unsigned      BIT_ODD_DIS    = 1;
  localparam int unsigned      BIT_RMII_CLK   = 0;
  // status register bit positions
  localparam int unsigned      ST_LED         = 0;
  localparam int unsigned      ST_ISOLATE     = 1;
  localparam int unsigned      ST_FDX         = 2;
  localparam int unsigned      ST_TX_OFF      = 3;
  localparam int unsigned      ST_STRAP_DONE  = 4;
  localparam int unsigned      ST_STRAP_VAL   = 5;
  // cycles after reset release before the strap is trusted
  localparam logic [1:0]       STRAP_SETTLE   = 2'h2;
  localparam int unsigned      SYNC_STAGES    = 2;
endpackage
`default_nettype wire

// ===== rtl/pcr_sync.sv
/*
  two-stage synchroniser for asynchronous pin levels.
  assumes inputs are slow levels; no event is guaranteed to pass.
*/
`timescale 1ns/1ps
`default_nettype none
module pcr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pcr_sync_state_t;

  pcr_sync_state_t r_reg;
  pcr_sync_state_t r_next;

  ////////////////////////////////////////////////////////////////////
  // per-bit chain; first stage feeds only the second
  always_comb begin
    r_next = r_reg;
    for (int i = 0; i < WIDTH; i++) begin
      r_next.meta[i]   = asyncIn[i];
      r_next.stable[i] = r_reg.meta[i];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign syncOut = r_reg.stable;
endmodule
`default_nettype wire

// ===== rtl/pcr_odd_nibble.sv
/*
  odd-nibble frame end check on the transmit enable stream.
  assumes one clock per transmit nibble and same-clock inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module pcr_odd_nibble (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic detectEn,
  input  wire logic txEnIn,
  input  wire logic txErIn,
  output var  logic txEnOut,
  output var  logic txErOut
);
  typedef struct packed {
    logic parity;
    logic txEnD;
    logic enOut;
    logic erOut;
  } pcr_nib_state_t;

  pcr_nib_state_t r_reg;
  pcr_nib_state_t r_next;
  logic           oddEnd;

  ////////////////////////////////////////////////////////////////////
  // R12 extend odd frame
  always_comb begin
    r_next       = r_reg;
    oddEnd       = r_reg.txEnD && !txEnIn && r_reg.parity && detectEn;
    r_next.txEnD = txEnIn;
    // parity of nibbles sent in the current frame
    r_next.parity = txEnIn ? !r_reg.parity : 1'b0;
    r_next.enOut  = txEnIn || oddEnd;
    r_next.erOut  = (txEnIn && txErIn) || oddEnd;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign txEnOut = r_reg.enOut;
  assign txErOut = r_reg.erOut;

  // R12 extension cycle
  odd_ext_a: assert property (@(posedge clock) disable iff (!rstn) // R12
    (r_reg.txEnD && !txEnIn && r_reg.parity && detectEn) |=> (txEnOut && txErOut))
    else $error("odd nibble end not extended with error");
  // R11 detection off
  odd_off_a: assert property (@(posedge clock) disable iff (!rstn) // R11
    (!detectEn && !txEnIn) |=> !txEnOut)
    else $error("extension while detection disabled");
endmodule
`default_nettype wire

// ===== rtl/pcr_phy_control_two.sv
/*
  second phy control register with the mode logic it steers: far-end
  link drop, fibre select, fast parallel detect, extended duplex,
  link led, mii isolate, idle symbol error gate, odd-nibble check and
  rmii receive reference select.
  assumes an avalon-mm master on the same clock and link status
  inputs from same-clock logic; only the fibre strap is a raw pin.
*/
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module pcr_phy_control_two #(
  parameter int unsigned DROP_HOLD_CYCLES = 1000
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        strapFibrePin,
  input  wire logic        fastMdixEn,
  input  wire logic        robustMdixEn,
  input  wire logic        linkUp,
  input  wire logic        speed100,
  input  wire logic        stdFullDuplex,
  input  wire logic        autoNegEn,
  input  wire logic        forced100,
  input  wire logic        partnerForced100,
  input  wire logic        activity,
  input  wire logic        rxIdle,
  input  wire logic        rxSymbolErr,
  input  wire logic        txEnIn,
  input  wire logic        txErIn,
  output var  logic        fibreMode,
  output var  logic        fastLinkUp,
  output var  logic        txDisable,
  output var  logic        fullDuplex,
  output var  logic        linkLed,
  output var  logic        miiIsolate,
  output var  logic        idleSymErr,
  output var  logic        rxRefSelect,
  output var  logic        txEnOut,
  output var  logic        txErOut
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] rdData;
    logic        ack;
    logic        waitReq;
    logic [1:0]  strapCnt;
    logic        strapDone;
    logic        linkUpD;
    logic [15:0] dropCnt;
    logic        txOff;
    logic        fdx;
    logic        led;
    logic        iso;
    logic        idleErr;
    logic        rxRef;
  } pcr_top_state_t;

  localparam logic [15:0] DROP_HOLD = 16'(DROP_HOLD_CYCLES);

  pcr_top_state_t r_reg;
  pcr_top_state_t r_next;
  logic           strapSync;
  logic           isCopper;
  logic           fdxNext;
  logic [15:0]    statusWord;
  logic [15:0]    wrData;

  ////////////////////////////////////////////////////////////////////
  // strap pin through two flops before use
  pcr_sync #(
    .WIDTH (1)
  ) u_strap_sync (
    .clock   (clock),
    .rstn    (rstn),
    .asyncIn (strapFibrePin),
    .syncOut (strapSync)
  );

  // R11 odd-nibble enable
  pcr_odd_nibble u_odd_nibble (
    .clock    (clock),
    .rstn     (rstn),
    .detectEn (!r_reg.ctrl[pcr_pkg::BIT_ODD_DIS]),
    .txEnIn   (txEnIn),
    .txErIn   (txErIn),
    .txEnOut  (txEnOut),
    .txErOut  (txErOut)
  );

  ////////////////////////////////////////////////////////////////////
  // status word shows block state, read only
  always_comb begin
    statusWord = '0;
    statusWord[pcr_pkg::ST_LED]        = r_reg.led;
    statusWord[pcr_pkg::ST_ISOLATE]    = r_reg.iso;
    statusWord[pcr_pkg::ST_FDX]        = r_reg.fdx;
    statusWord[pcr_pkg::ST_TX_OFF]     = r_reg.txOff;
    statusWord[pcr_pkg::ST_STRAP_DONE] = r_reg.strapDone;
    statusWord[pcr_pkg::ST_STRAP_VAL]  = strapSync;
  end

  // R15 byte lanes merge, reserved bits kept as written
  always_comb begin
    wrData = r_reg.ctrl;
    if (avs_byteenable[0]) begin
      wrData[7:0] = avs_writedata[7:0];
    end
    if (avs_byteenable[1]) begin
      wrData[15:8] = avs_writedata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // next state: bus slave, strap load, mode logic
  always_comb begin
    r_next   = r_reg;
    isCopper = !r_reg.ctrl[pcr_pkg::BIT_FIBRE];
    // one wait state: ack the cycle after a request is seen
    r_next.ack     = (avs_read || avs_write) && !r_reg.ack;
    r_next.waitReq = !r_next.ack;
    if (r_next.ack && avs_read) begin
      // R1 register decode
      if (avs_address == pcr_pkg::ADDR_CTRL_TWO) begin
        r_next.rdData = r_reg.ctrl;
      end else if (avs_address == pcr_pkg::ADDR_STATUS) begin
        r_next.rdData = statusWord;
      end else begin
        r_next.rdData = '0;
      end
    end
    // write lands on the edge the master sees waitrequest low
    if (r_reg.ack && avs_write) begin
      if (avs_address == pcr_pkg::ADDR_CTRL_TWO) begin
        r_next.ctrl = wrData;
      end
    end
    // R3 strap loads fibre bit once after reset
    if (!r_reg.strapDone) begin
      r_next.strapCnt = r_reg.strapCnt + 2'h1;
      if (r_reg.strapCnt == pcr_pkg::STRAP_SETTLE) begin
        r_next.ctrl[pcr_pkg::BIT_FIBRE] = strapSync;
        r_next.strapDone                = 1'b1;
        r_next.strapCnt                 = r_reg.strapCnt;
      end
    end
    // R5 hardware set wins over a software clear
    if (fastMdixEn || robustMdixEn) begin
      r_next.ctrl[pcr_pkg::BIT_FAST_PD] = 1'b1;
    end
    // R2 hold transmitter off for a while after a 100M drop
    r_next.linkUpD = linkUp;
    if (linkUp) begin
      r_next.dropCnt = '0;
    end else if (r_reg.linkUpD && r_reg.ctrl[pcr_pkg::BIT_FAR_DROP] && speed100) begin
      r_next.dropCnt = DROP_HOLD;
    end else if (r_reg.dropCnt != '0) begin
      r_next.dropCnt = r_reg.dropCnt - 16'h0001;
    end
    r_next.txOff = (r_next.dropCnt != '0) && r_reg.ctrl[pcr_pkg::BIT_FAR_DROP];
    // R6 extended duplex against a forced 100M partner
    fdxNext = linkUp && (stdFullDuplex ||
              (r_reg.ctrl[pcr_pkg::BIT_EXT_FDX] && isCopper && speed100 &&
               partnerForced100 && (autoNegEn || forced100)));
    r_next.fdx = fdxNext;
    // R7 enhanced led qualifies link
    if (r_reg.ctrl[pcr_pkg::BIT_ENH_LED]) begin
      // R8 no activity blink in enhanced mode
      r_next.led = linkUp && speed100 && fdxNext && isCopper;
    end else begin
      r_next.led = linkUp && !activity;
    end
    // R9 isolate on half-duplex 100M copper or any 10M link
    r_next.iso = r_reg.ctrl[pcr_pkg::BIT_ISO_MII] && linkUp &&
                 ((speed100 && !fdxNext && isCopper) || !speed100);
    // R10 idle symbol error gate
    r_next.idleErr = r_reg.ctrl[pcr_pkg::BIT_IDLE_ERR] && rxIdle && rxSymbolErr;
    // R13 R14 rmii receive reference select
    r_next.rxRef = r_reg.ctrl[pcr_pkg::BIT_RMII_CLK];
  end

  ////////////////////////////////////////////////////////////////////
  // register the whole state
  always_ff @(posedge clock) begin
    if (!rstn) begin
      r_reg         <= '0;
      // R10 idle error detection on at reset
      r_reg.ctrl    <= pcr_pkg::RESET_CTRL_TWO;
      r_reg.waitReq <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from state flops
  assign avs_readdata    = {16'h0000, r_reg.rdData};
  assign avs_waitrequest = r_reg.waitReq;
  assign fibreMode       = r_reg.ctrl[pcr_pkg::BIT_FIBRE];
  // R4 fast parallel-detect select
  assign fastLinkUp      = r_reg.ctrl[pcr_pkg::BIT_FAST_PD];
  assign txDisable       = r_reg.txOff;
  assign fullDuplex      = r_reg.fdx;
  assign linkLed         = r_reg.led;
  assign miiIsolate      = r_reg.iso;
  assign idleSymErr      = r_reg.idleErr;
  assign rxRefSelect     = r_reg.rxRef;

  ////////////////////////////////////////////////////////////////////
  // checks on the steered outputs
  // R1 read returns register
  reg_read_a: assert property (@(posedge clock) disable iff (!rstn) // R1
    (avs_read && !avs_waitrequest && avs_address == pcr_pkg::ADDR_CTRL_TWO)
      |-> avs_readdata[15:0] == $past(r_reg.ctrl))
    else $error("control register read mismatch");
  // R2 drop turns tx off
  tx_drop_a: assert property (@(posedge clock) disable iff (!rstn) // R2
    ($fell(linkUp) && r_reg.ctrl[pcr_pkg::BIT_FAR_DROP] && speed100 &&
     !$past(avs_write)) |=> txDisable)
    else $error("transmitter not disabled on link drop");
  // R3 strap load
  strap_load_a: assert property (@(posedge clock) disable iff (!rstn) // R3
    $rose(r_reg.strapDone) |-> fibreMode == $past(strapSync))
    else $error("fibre bit not loaded from strap");
  // R5 auto set
  fast_set_a: assert property (@(posedge clock) disable iff (!rstn) // R5
    (fastMdixEn || robustMdixEn) |=> fastLinkUp)
    else $error("fast link-up bit not forced");
  // R6 extended duplex
  ext_fdx_a: assert property (@(posedge clock) disable iff (!rstn) // R6
    (linkUp && speed100 && r_reg.ctrl[pcr_pkg::BIT_EXT_FDX] && !fibreMode &&
     partnerForced100 && forced100) |=> fullDuplex)
    else $error("extended duplex not applied");
  // R7 enhanced led
  led_enh_a: assert property (@(posedge clock) disable iff (!rstn) // R7
    (r_reg.ctrl[pcr_pkg::BIT_ENH_LED] && !speed100) |=> !linkLed)
    else $error("enhanced led lit on 10M link");
  // R8 no blink
  led_blink_a: assert property (@(posedge clock) disable iff (!rstn) // R8
    (r_reg.ctrl[pcr_pkg::BIT_ENH_LED] && linkUp && speed100 && !fibreMode &&
     stdFullDuplex) |=> linkLed)
    else $error("enhanced led blinked or dark");
  // R9 isolate on 10M
  mii_iso_a: assert property (@(posedge clock) disable iff (!rstn) // R9
    (r_reg.ctrl[pcr_pkg::BIT_ISO_MII] && linkUp && !speed100) |=> miiIsolate)
    else $error("mii not isolated on 10M link");
  // R10 gate off while bit2 is clear
  idle_err_a: assert property (@(posedge clock) disable iff (!rstn) // R10
    (!r_reg.ctrl[pcr_pkg::BIT_IDLE_ERR]) |=> !idleSymErr)
    else $error("idle symbol error while disabled");
  // R13 reference follows bit
  rx_ref_a: assert property (@(posedge clock) disable iff (!rstn) // R13 R14
    1'b1 |=> rxRefSelect == $past(r_reg.ctrl[pcr_pkg::BIT_RMII_CLK]))
    else $error("rmii reference select stale");

  ////////////////////////////////////////////////////////////////////
  // bus handshake and steady-state guards; these catch a decode that
  // drifts between the scenario-level checks above
  // R1 one wait state
  wait_one_a: assert property (@(posedge clock) disable iff (!rstn) // R1
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  // R1 answer lasts one cycle
  ack_once_a: assert property (@(posedge clock) disable iff (!rstn) // R1
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // R15 full write stored
  wr_store_a: assert property (@(posedge clock) disable iff (!rstn) // R15
    (avs_write && !avs_waitrequest && avs_address == pcr_pkg::ADDR_CTRL_TWO &&
     avs_byteenable[1:0] == 2'h3 && r_reg.strapDone && !fastMdixEn && !robustMdixEn)
      |=> r_reg.ctrl == $past(avs_writedata[15:0]))
    else $error("control write not stored as given");
  // R2 link up clears hold
  tx_up_a: assert property (@(posedge clock) disable iff (!rstn) // R2
    linkUp |=> !txDisable)
    else $error("transmitter held off while link up");
  // R2 mode off keeps tx
  tx_mode_a: assert property (@(posedge clock) disable iff (!rstn) // R2
    !r_reg.ctrl[pcr_pkg::BIT_FAR_DROP] |=> !txDisable)
    else $error("transmitter off with far-end drop disabled");
  // R3 fibre bit steady
  fibre_hold_a: assert property (@(posedge clock) disable iff (!rstn) // R3
    (r_reg.strapDone && !(avs_write && !avs_waitrequest)) |=> $stable(fibreMode))
    else $error("fibre bit changed without a write");
  // R6 standard duplex kept
  fdx_std_a: assert property (@(posedge clock) disable iff (!rstn) // R6
    (linkUp && stdFullDuplex) |=> fullDuplex)
    else $error("standard full duplex lost");
  // R7 normal led lit
  led_norm_a: assert property (@(posedge clock) disable iff (!rstn) // R7
    (!r_reg.ctrl[pcr_pkg::BIT_ENH_LED] && linkUp && !activity) |=> linkLed)
    else $error("normal led dark on idle link");
  // R9 isolate off when disabled
  iso_off_a: assert property (@(posedge clock) disable iff (!rstn) // R9
    !r_reg.ctrl[pcr_pkg::BIT_ISO_MII] |=> !miiIsolate)
    else $error("mii isolated while mode disabled");
  // R10 idle error reported
  idle_on_a: assert property (@(posedge clock) disable iff (!rstn) // R10
    (r_reg.ctrl[pcr_pkg::BIT_IDLE_ERR] && rxIdle && rxSymbolErr) |=> idleSymErr)
    else $error("idle symbol error not reported");
endmodule
`default_nettype wire

// ===== dv/pcr_mac_model.sv
/*
  mac-side transmit model: sends one frame of a given nibble count.
  assumes go is a one-cycle pulse from the bench on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pcr_mac_model (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       go,
  input  wire logic [3:0] nibbles,
  output var  logic       txEn,
  output var  logic       txEr
);
  logic [3:0] nibLeft_reg;
  //////////////////////////////////////////////////////////////////////
  // nibble counter; a frame is never cut short or restarted mid-way
  always_ff @(posedge clock) begin
    if (!rstn) begin
      nibLeft_reg <= 4'h0;
    end else if (go && nibLeft_reg == 4'h0) begin
      nibLeft_reg <= nibbles;
    end else if (nibLeft_reg != 4'h0) begin
      nibLeft_reg <= nibLeft_reg - 4'h1;
    end
  end
  // clean frames, so any error seen downstream comes from the check
  assign txEn = (nibLeft_reg != 4'h0);
  assign txEr = 1'b0;
endmodule
`default_nettype wire

// ===== dv/test_pcr_phy_control_two.sv
/*
  self-checking bench for the second phy control register block.
  assumes the mac model is compiled first; one 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pcr_phy_control_two;
  localparam int unsigned HOLD = 8;
  localparam logic [7:0]  A    = pcr_pkg::ADDR_CTRL_TWO;
  logic        clock = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
  logic [3:0]  avs_byteenable = 4'hF, nibbles = 4'h0;
  logic        avs_waitrequest, txEnIn, txErIn, go = 1'b0;
  logic        strapFibrePin = 1'b1, fastMdixEn = 1'b0, robustMdixEn = 1'b0, linkUp = 1'b0;
  logic        speed100 = 1'b0, stdFullDuplex = 1'b0, autoNegEn = 1'b0, activity = 1'b0;
  logic        partnerForced100 = 1'b0, rxIdle = 1'b0, rxSymbolErr = 1'b0, forced100 = 1'b0;
  logic        fibreMode, fastLinkUp, txDisable, fullDuplex, linkLed, miiIsolate;
  logic        idleSymErr, rxRefSelect, txEnOut, txErOut;
  logic [31:0] expQ[$];
  logic [31:0] seed = 32'h00002AE5;
  logic [4:0]  ledTab[5] = '{5'b01111, 5'b01000, 5'b00001, 5'b11100, 5'b00110};
  logic [3:0]  isoTab[4] = '{4'b1011, 4'b1101, 4'b1110, 4'b0000};
  logic [9:0]  nibTab[3] = '{10'b0001101001, 10'b0010001000, 10'b1001100110};
  int          miscompares = 0;
  int          cmp_count = 0;
  int          n, e;

  always #2 clock = ~clock;

  pcr_phy_control_two #(.DROP_HOLD_CYCLES(HOLD)) i_dut (
    .clock(clock), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .strapFibrePin(strapFibrePin), .fastMdixEn(fastMdixEn), .robustMdixEn(robustMdixEn),
    .linkUp(linkUp), .speed100(speed100), .stdFullDuplex(stdFullDuplex),
    .autoNegEn(autoNegEn), .forced100(forced100), .partnerForced100(partnerForced100),
    .activity(activity), .rxIdle(rxIdle), .rxSymbolErr(rxSymbolErr), .txEnIn(txEnIn),
    .txErIn(txErIn), .fibreMode(fibreMode), .fastLinkUp(fastLinkUp),
    .txDisable(txDisable), .fullDuplex(fullDuplex), .linkLed(linkLed),
    .miiIsolate(miiIsolate), .idleSymErr(idleSymErr), .rxRefSelect(rxRefSelect),
    .txEnOut(txEnOut), .txErOut(txErOut));

  pcr_mac_model i_mac (.clock(clock), .rstn(rstn), .go(go), .nibbles(nibbles),
    .txEn(txEnIn), .txEr(txErIn));

  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // one avalon transfer; the request holds until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] be);
    avs_address    <= a;
    avs_write      <= w;
    avs_read       <= ~w;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= be;
    // no local limit: a hung slave is ended by the watchdog
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [15:0] d);
    bus(1'b1, A, d, 4'h3);
    repeat (3) @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    expQ.push_back(exp);
    bus(1'b0, a, 16'h0000, 4'hF);
  endtask

  //////////////////////////////////////////////////////////////////////
  // read results: oldest note against the data returned
  always @(posedge clock) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      check(avs_readdata, expQ.size() > 0 ? expQ.pop_front() : 32'hFFFFFFFF);
    end
  end

  // watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock);
    rd(A, {16'h0000, pcr_pkg::RESET_CTRL_TWO | 16'h4000});
    check(fibreMode, 1'b1);
    rd(8'h2C, 32'h00000000);
    // status writes are ignored; strap loaded and high
    bus(1'b1, pcr_pkg::ADDR_STATUS, 16'hFFFF, 4'h3);
    rd(pcr_pkg::ADDR_STATUS, 32'h00000030);
    // low lane only; bit7 kept at its reserved default
    bus(1'b1, A, 16'h007F, 4'h1);
    rd(A, 32'h0000417F);
    wr(16'h0104);
    check(fibreMode, 1'b0);
    $display("done: reset and access");
    // random fields, reserved bits 13..7 written back at their default
    for (int i = 0; i < 4; i++) begin
      logic [15:0] d;
      seed = xs(seed);
      d = (seed[15:0] & 16'hC07F) | 16'h0100;
      bus(1'b1, A, d, 4'h3);
      rd(A, {16'h0000, d});
    end
    for (int b = 0; b < 2; b++) begin
      wr(16'h0104 | 16'(b));
      check(rxRefSelect, b[0]);
    end
    wr(16'h0144);
    check(fastLinkUp, 1'b1);
    for (int m = 0; m < 3; m++) begin
      fastMdixEn <= (m == 1);
      robustMdixEn <= (m == 2);
      wr(16'h0104);
      check(fastLinkUp, m != 0);
      rd(A, m != 0 ? 32'h00000144 : 32'h00000104);
    end
    fastMdixEn <= 1'b0;
    robustMdixEn <= 1'b0;
    $display("done: mode bits");
    linkUp <= 1'b1;
    speed100 <= 1'b1;
    autoNegEn <= 1'b1;
    partnerForced100 <= 1'b1;
    // auto-negotiating, then forced 100M, each with bit5 off and on
    for (int b = 0; b < 4; b++) begin
      autoNegEn <= !b[1];
      forced100 <= b[1];
      wr(b[0] ? 16'h0124 : 16'h0104);
      check(fullDuplex, b[0]);
    end
    stdFullDuplex <= 1'b1;
    foreach (ledTab[i]) begin
      speed100 <= ledTab[i][2];
      activity <= ledTab[i][1];
      wr(16'h0104 | {1'b0, ledTab[i][4], 9'h000, ledTab[i][3], 4'h0});
      check(linkLed, ledTab[i][0]);
    end
    activity <= 1'b0;
    foreach (isoTab[i]) begin
      speed100 <= isoTab[i][2];
      stdFullDuplex <= isoTab[i][1];
      wr(16'h0104 | {12'h000, isoTab[i][3], 3'h0});
      check(miiIsolate, isoTab[i][0]);
    end
    rxIdle <= 1'b1;
    rxSymbolErr <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      wr(b ? 16'h0104 : 16'h0100);
      check(idleSymErr, b[0]);
    end
    $display("done: link modes");
    speed100 <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      wr(b ? 16'h8104 : 16'h0104);
      linkUp <= 1'b0;
      n = 0;
      repeat (20) begin
        @(posedge clock);
        n += (txDisable === 1'b1);
      end
      check(n, b ? HOLD : 0);
      linkUp <= 1'b1;
      repeat (3) @(posedge clock);
    end
    foreach (nibTab[i]) begin
      wr(16'h0104 | {14'h0000, nibTab[i][9], 1'b0});
      nibbles <= nibTab[i][8:5];
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      n = 0;
      e = 0;
      repeat (12) begin
        @(posedge clock);
        n += (txEnOut === 1'b1);
        e += (txErOut === 1'b1);
      end
      check(n, nibTab[i][4:1]);
      check(e, nibTab[i][0]);
    end
    $display("done: drop and transmit");
    report_and_stop();
  end
endmodule
`default_nettype wire
